// ### design/asr_defs.svh
// timing constants for the asynchronous static memory controller
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH
`define ASR_CLK_PERIOD_NS              20
`define ASR_READ_CYCLE_MIN_NS          55
`define ASR_ADDRESS_ACCESS_TIME_NS     55
`define ASR_SELECT_ACCESS_TIME_NS      55
`define ASR_OE_ACCESS_TIME_NS          25
`define ASR_READ_DATA_HOLD_NS          10
`define ASR_WRITE_CYCLE_MIN_NS         55
`define ASR_ADDRESS_TO_WRITE_END_NS    40
`define ASR_WRITE_STROBE_LOW_WIDTH_NS  40
`define ASR_DATA_BEFORE_WRITE_END_NS   25
`define ASR_DATA_AFTER_WRITE_END_NS    0
`define ASR_RETENTION_RECOVERY_NS      55
`define ASR_CYC_UP(ns) (((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
`define ASR_READ_CYC   `ASR_CYC_UP(`ASR_READ_CYCLE_MIN_NS)
`define ASR_WRITE_CYC  `ASR_CYC_UP(`ASR_WRITE_STROBE_LOW_WIDTH_NS)
`define ASR_RECOVER_CYC `ASR_CYC_UP(`ASR_RETENTION_RECOVERY_NS)
`endif

// ### design/asr_pkg.sv
// types for the asynchronous static memory controller
package asr_pkg;
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_READ    = 6'h02,
    ST_WRITE   = 6'h04,
    ST_WEND    = 6'h08,
    ST_RETAIN  = 6'h10,
    ST_RECOVER = 6'h20
  } asr_state_t;
endpackage

// ### design/asr_ctrl.sv
// host-side controller driving an asynchronous 512k x 8 static memory
`timescale 1ns/1ps
`include "asr_defs.svh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// [RQ1] write only while select and strobe low
// [RQ2] device commits during strobe and select overlap
// [RQ3] data set 25 ns before write end
// [RQ4] read: strobe high, select and enable low
// [RQ5] device floats lines when enable high
// [RQ6] device floats when select and strobe rise
// [RQ7] never drive lines during a read
// [RQ8] read data valid 55 ns after address
// [RQ9] old data held 10 ns after address
// [RQ10] read data valid 55 ns after select
// [RQ11] read data valid 25 ns after enable
// [RQ12] address, strobe, select low 40 ns
// [RQ13] zero address setup and hold allowed
// [RQ14] select high before and during retention
// [RQ15] wait 55 ns after supply returns
// [RQ16] device standby when select high
// [RQ17] round every minimum up to cycles
module asr_ctrl #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              reqValid,
  input  wire logic              reqWrite,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqWdata,
  output logic                   reqReady,
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspRdata,
  input  wire logic              retainReq,
  output logic                   retainOk,
  output logic [ADDR_W-1:0]      memAddr,
  output logic                   memSelectN,
  output logic                   memWriteN,
  output logic                   memOutEnN,
  input  wire logic [DATA_W-1:0] memDataIn,
  output logic [DATA_W-1:0]      memDataOut,
  output logic                   memDataOe
);
  localparam int CW = 4;
  localparam logic [CW-1:0] RD_CYC  = CW'(`ASR_READ_CYC);
  localparam logic [CW-1:0] WR_CYC  = CW'(`ASR_WRITE_CYC);
  localparam logic [CW-1:0] REC_CYC = CW'(`ASR_RECOVER_CYC);

  // pin map and counters are sized for this one organisation only
  if (ADDR_W != 19 || DATA_W != 8) begin : g_bad_width
    $error("asr_ctrl serves only 19 address and 8 data bits");
  end

  //////////////////////////////////////////////////////////////////////////////
  // two-flop sync on the data pins and retention request
  logic [DATA_W-1:0] dSync1, dSync2;
  logic              rSync1, rSync2;
  always_ff @(posedge sys_clk) begin
    dSync1 <= memDataIn;
    dSync2 <= dSync1;
    rSync1 <= retainReq;
    rSync2 <= rSync1;
  end

  //////////////////////////////////////////////////////////////////////////////
  asr_pkg::asr_state_t state, next_state;
  logic [CW-1:0]       cnt, next_cnt;
  logic [ADDR_W-1:0]   next_memAddr;
  logic                next_memSelectN, next_memWriteN, next_memOutEnN, next_memDataOe;
  logic [DATA_W-1:0]   next_memDataOut, next_rspRdata;
  logic                next_reqReady, next_rspValid, next_retainOk;

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_memAddr    = memAddr;
    next_memSelectN = memSelectN;
    next_memWriteN  = memWriteN;
    next_memOutEnN  = memOutEnN;
    next_memDataOe  = memDataOe;
    next_memDataOut = memDataOut;
    next_rspRdata   = rspRdata;
    next_rspValid   = 1'b0;
    next_reqReady   = 1'b0;
    next_retainOk   = 1'b0;
    case (state)
      asr_pkg::ST_IDLE: begin
        next_memSelectN = 1'b1; // [RQ16]
        next_memWriteN  = 1'b1;
        next_memOutEnN  = 1'b1;
        next_memDataOe  = 1'b0;
        if (rSync2) begin
          next_state    = asr_pkg::ST_RETAIN; // [RQ14]
          next_retainOk = 1'b1;
        end else if (reqValid && reqReady) begin
          next_memAddr    = reqAddr; // [RQ13]
          next_memSelectN = 1'b0;
          next_cnt        = '0;
          if (reqWrite) begin
            next_memWriteN  = 1'b0; // [RQ1]
            next_memDataOut = reqWdata;
            next_memDataOe  = 1'b1; // [RQ3]
            next_state      = asr_pkg::ST_WRITE;
          end else begin
            next_memOutEnN = 1'b0; // [RQ4]
            next_state     = asr_pkg::ST_READ;
          end
        end else begin
          next_reqReady = 1'b1;
        end
      end
      asr_pkg::ST_READ: begin
        next_cnt = cnt + 1'b1;
        // two sync flops add latency, so sample after the access plus two
        if (cnt == RD_CYC + CW'(2)) begin // [RQ8] [RQ10] [RQ11] [RQ17]
          next_rspRdata   = dSync2;
          next_rspValid   = 1'b1;
          next_memSelectN = 1'b1;
          next_memOutEnN  = 1'b1;
          next_state      = asr_pkg::ST_IDLE;
        end
      end
      asr_pkg::ST_WRITE: begin
        next_cnt = cnt + 1'b1;
        if (cnt == WR_CYC - CW'(1)) begin // [RQ12] [RQ17]
          next_memWriteN  = 1'b1; // [RQ1]
          next_memSelectN = 1'b1;
          next_state      = asr_pkg::ST_WEND;
        end
      end
      asr_pkg::ST_WEND: begin
        // data held one cycle past the strobe edge for margin
        next_memDataOe = 1'b0;
        next_state     = asr_pkg::ST_IDLE;
      end
      asr_pkg::ST_RETAIN: begin
        next_retainOk = 1'b1;
        if (!rSync2) begin
          next_retainOk = 1'b0;
          next_cnt      = '0;
          next_state    = asr_pkg::ST_RECOVER;
        end
      end
      asr_pkg::ST_RECOVER: begin
        next_cnt = cnt + 1'b1;
        if (cnt == REC_CYC - CW'(1)) begin // [RQ15]
          next_state = asr_pkg::ST_IDLE;
        end
      end
      default: next_state = asr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state      <= asr_pkg::ST_IDLE;
      cnt        <= '0;
      memAddr    <= '0;
      memSelectN <= 1'b1;
      memWriteN  <= 1'b1;
      memOutEnN  <= 1'b1;
      memDataOe  <= 1'b0;
      memDataOut <= '0;
      rspRdata   <= '0;
      rspValid   <= 1'b0;
      reqReady   <= 1'b0;
      retainOk   <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      memAddr    <= next_memAddr;
      memSelectN <= next_memSelectN;
      memWriteN  <= next_memWriteN;
      memOutEnN  <= next_memOutEnN;
      memDataOe  <= next_memDataOe;
      memDataOut <= next_memDataOut;
      rspRdata   <= next_rspRdata;
      rspValid   <= next_rspValid;
      reqReady   <= next_reqReady;
      retainOk   <= next_retainOk;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_no_drive_in_read;
    @(posedge sys_clk) disable iff (srst) !memOutEnN |-> !memDataOe;
  endproperty
  a_no_drive_in_read: assert property (p_no_drive_in_read) else $error("data driven during read"); // [RQ7]

  property p_write_overlap;
    @(posedge sys_clk) disable iff (srst) !memWriteN |-> !memSelectN && memDataOe;
  endproperty
  a_write_overlap: assert property (p_write_overlap) else $error("strobe low without select or data"); // [RQ1]

  property p_strobe_width;
    @(posedge sys_clk) disable iff (srst) $fell(memWriteN) |-> !memWriteN [*2];
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("write strobe too short"); // [RQ12]

  property p_data_setup;
    @(posedge sys_clk) disable iff (srst) $rose(memWriteN) |-> memDataOe && $past(memDataOe, 2);
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("write data setup short"); // [RQ3]

  property p_data_hold;
    @(posedge sys_clk) disable iff (srst) $rose(memWriteN) |-> memDataOe && $stable(memDataOut);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data not held"); // [RQ3]

  property p_read_time;
    @(posedge sys_clk) disable iff (srst) $fell(memOutEnN) |-> !memOutEnN [*6] ##1 (rspValid && memOutEnN);
  endproperty
  a_read_time: assert property (p_read_time) else $error("read window wrong"); // [RQ8]

  property p_addr_stable;
    @(posedge sys_clk) disable iff (srst) !memSelectN && !$fell(memSelectN) |-> $stable(memAddr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved while selected"); // [RQ12]

  property p_retain_deselect;
    @(posedge sys_clk) disable iff (srst) retainOk |-> memSelectN && memWriteN;
  endproperty
  a_retain_deselect: assert property (p_retain_deselect) else $error("selected during retention"); // [RQ14]

  property p_recover;
    @(posedge sys_clk) disable iff (srst) $fell(retainOk) |-> memSelectN [*3];
  endproperty
  a_recover: assert property (p_recover) else $error("access too soon after retention"); // [RQ15]
endmodule

// ### test/asr_mem_model.sv
// behavioural model of the asynchronous 512k x 8 static memory
`timescale 1ns/1ps
module asr_mem_model #(
  parameter int ACC = 50
) (
  input  wire logic [18:0] memAddr,
  input  wire logic        memSelectN,
  input  wire logic        memWriteN,
  input  wire logic        memOutEnN,
  input  wire logic [7:0]  memDataOut,
  input  wire logic        memDataOe,
  output logic [7:0]       memDataIn,
  output logic             drive,
  output logic             setupBad
);
  logic [7:0] mem [0:(1 << 19) - 1];
  logic [7:0] busLvl;
  logic       armed;
  realtime    tData;
  initial begin
    memDataIn = 8'h00;
    setupBad = 1'b0;
    armed = 1'b0;
    tData = 0;
    for (int i = 0; i < (1 << 19); i++) mem[i] = 8'h5a;
  end
  // data out only with select low, strobe high, enable low
  assign drive = !memSelectN && memWriteN && !memOutEnN;
  assign busLvl = memDataOe ? memDataOut : memDataIn;
  // slow answer; undriven lines invert on release and on each address change
  always @(drive or memAddr) begin
    if (drive)
      memDataIn <= #ACC mem[memAddr];
    else
      memDataIn <= #10 ~memDataIn;
  end
  always @(busLvl) tData = $realtime;
  // armed only by a real overlap, so the reset rise from x is no write
  always @(negedge (memSelectN | memWriteN)) armed = 1'b1;
  // write ends at whichever of select or strobe rises first
  always @(posedge (memSelectN | memWriteN)) begin
    if (armed) begin
      if ($realtime - tData < 25) setupBad = 1'b1;
      mem[memAddr] = busLvl;
      armed = 1'b0;
    end
  end
endmodule

// ### test/asr_ctrl_bench.sv
// self-checking bench for the static memory controller
`timescale 1ns/1ps
module asr_ctrl_bench;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic [18:0] reqAddr = 19'h00000;
  logic [7:0]  reqWdata = 8'h00;
  logic        retainReq = 1'b0;
  logic        reqReady, rspValid, retainOk, memSelectN, memWriteN, memOutEnN, memDataOe, drive, setupBad;
  logic [7:0]  rspRdata, memDataIn, memDataOut;
  logic [18:0] memAddr;
  int          n_fail = 0;
  int          checked = 0;
  int          selLow = 0;
  int          weLow = 0;
  int          lastSel = 0;
  int          lastWe = 0;
  asr_ctrl DUT (.sys_clk, .srst, .reqValid, .reqWrite, .reqAddr, .reqWdata, .reqReady, .rspValid, .rspRdata,
    .retainReq, .retainOk, .memAddr, .memSelectN, .memWriteN, .memOutEnN, .memDataIn, .memDataOut, .memDataOe);
  asr_mem_model MEM (.memAddr, .memSelectN, .memWriteN, .memOutEnN, .memDataOut, .memDataOe, .memDataIn,
    .drive, .setupBad);
  initial forever #10 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    selLow <= memSelectN ? 0 : selLow + 1;
    weLow <= memWriteN ? 0 : weLow + 1;
    if (!memSelectN) lastSel <= selLow + 1;
    if (!memWriteN) lastWe <= weLow + 1;
    if (memDataOe === 1'b1 && drive === 1'b1) chk("contention", 0, 1);
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // bounded wait; edges are sampled before this edge's updates land
  task automatic waitFor(ref logic sig, input logic lvl, output int n);
    for (n = 1; n <= 60; n++) begin
      @(posedge sys_clk);
      if (sig === lvl) return;
    end
    chk("timeout", 0, 1);
    summarize();
  endtask
  task automatic req(input logic w, input logic [18:0] a, input logic [7:0] d);
    int n;
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= a;
    reqWdata <= d;
    waitFor(reqReady, 1'b1, n);
    reqValid <= 1'b0;
    @(posedge sys_clk);
    chk("ready while busy", 0, reqReady);
  endtask
  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    int n;
    req(1'b1, a, d);
    waitFor(reqReady, 1'b1, n);
    chk("strobe low cycles", 1, lastWe >= 2);
  endtask
  task automatic rd(input logic [18:0] a, input logic [7:0] d);
    int n;
    req(1'b0, a, 8'h00);
    waitFor(rspValid, 1'b1, n);
    chk("read latency", 6, n);
    chk("read data", d, rspRdata);
    chk("select low cycles", 1, lastSel >= 3);
  endtask
  task automatic t_rw();
    wr(19'h7ffff, 8'ha5);
    wr(19'h00000, 8'h3c);
    rd(19'h7ffff, 8'ha5);
    rd(19'h00000, 8'h3c);
    wr(19'h00000, 8'hc3);
    rd(19'h00000, 8'hc3);
    chk("data setup", 0, setupBad);
    $display("test rw done");
  endtask
  task automatic t_retain();
    int n;
    retainReq <= 1'b1;
    waitFor(retainOk, 1'b1, n);
    repeat (4) begin
      @(posedge sys_clk);
      chk("select in retention", 1, memSelectN);
    end
    retainReq <= 1'b0;
    waitFor(retainOk, 1'b0, n);
    waitFor(reqReady, 1'b1, n);
    chk("recovery cycles", 1, n >= 3);
    rd(19'h7ffff, 8'ha5);
    $display("test retain done");
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    t_rw();
    t_retain();
    summarize();
  end
endmodule
